// File: logic/flow_alarm_pkg.sv
// Shared constants and types for the flow alarm supervisor.
// Assumes one 250 MHz system clock and 32-bit Avalon-MM register access.
package flow_alarm_pkg;

	// Clock and timing figures.
	localparam int CLK_PERIOD_NS  = 4;              // System clock period in ns.
	localparam int SEC_NS         = 1000000000;     // One second in ns.
	localparam int CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
	localparam int ALARM_DELAY_S  = 10;             // Alarm, reselect and idle delay in seconds.
	localparam logic [3:0] DELAY_TICKS = 4'(ALARM_DELAY_S); // Delay as a count of one-second ticks.

	// Source indices and counts.
	localparam int NUM_SRC  = 3;                    // Alarm sources.
	localparam int SRC_OVER = 0;                    // Over differential pressure.
	localparam int SRC_EXT  = 1;                    // External contact input.
	localparam int SRC_LOW  = 2;                    // Low or no flow.
	localparam int TMR_IDLE = 3;                    // Keypad idle timer index.
	localparam int NUM_TMR  = 4;                    // Three source timers plus the idle timer.
	localparam int FLOW_W   = 16;                   // Flow sample width.

	// Register byte offsets.
	localparam logic [4:0] REG_PEND   = 5'h00;      // Pending configuration, read/write.
	localparam logic [4:0] REG_ENTER  = 5'h04;      // Enter action, write only.
	localparam logic [4:0] REG_CONFIG = 5'h08;      // Stored configuration, read only.
	localparam logic [4:0] REG_STATUS = 5'h0c;      // Alarm and view status, read only.
	localparam logic [4:0] REG_HIHI   = 5'h10;      // High-high flow limit.
	localparam logic [4:0] REG_MINFL  = 5'h14;      // Minimum flow rate.

	// Field positions.
	localparam int CFG_W        = 6;                // Width of the configuration word.
	localparam int ENTER_BIT    = 0;                // Commit strobe in the enter register.
	localparam int ST_ANY_BIT   = 3;                // Any alarm active.
	localparam int ST_VIEW_LSB  = 4;                // Current view, three bits.
	localparam int ST_ARMED_BIT = 7;                // Low flow alarm armed.
	localparam int ST_EXT_BIT   = 8;                // External input seen low.

	// Reset values.
	localparam logic [5:0]  CFG_RST   = 6'h00;      // Nothing selected, relay disabled.
	localparam logic [15:0] HIHI_RST  = 16'hffff;   // Limit parked at full scale.
	localparam logic [15:0] MINFL_RST = 16'h0000;   // Minimum flow parked at zero.

	// Stored or pending configuration, packed so that it maps onto the register bits.
	typedef struct packed
	{
		logic       relay_en;                       // Master alarm relay enable.
		logic       beep_en;                        // Audible beeper option.
		logic       msg_en;                         // Alarm message option.
		logic [2:0] sel;                            // Per-source select bits.
	} cfg_s;

	// Views the display logic can select.
	typedef enum logic [2:0]
	{
		VIEW_FLOW,
		VIEW_ALARM,
		VIEW_SERVICE,
		VIEW_TOTAL,
		VIEW_TOTAL_RST,
		VIEW_OTHER
	} view_e;

endpackage

// File: logic/flow_alarm_manager.sv
// Alarm supervision for a liquid flow instrument: sources, latches, notification and default view.
// Assumes FLOW_RATE and keypad strobes come from logic on MCLK; EXT_ALARM_N is an asynchronous pin.
// How it works
// - Three sources, each with stored select bit.
// - Pending settings commit only on enter.
// - Any select bit may change anytime.
// - No alarm activates without relay enable.
// - Message and beeper options independently selectable.
// - Raised alarm latches until source deselected.
// - Reselected persisting cause raises after ten seconds.
// - Relay re-enable reactivates persisting alarm.
// - Active alarm drives message indication.
// - Active alarms make alarm view default.
// - Relay disable suppresses alarm default view.
// - Service view leaves only on navigation.
// - Over-limit flow raises over pressure alarm.
// - Over pressure alarm needs safe flow and deselect.
// - Flow below minimum raises low flow alarm.
// - Low flow alarm armed after first flow.
// - Low flow alarm needs flow and deselect.
// - Grounded external input alarms after ten seconds.
// - External alarm needs input high and deselect.
// - Idle ten seconds returns to flow view, except from alarm, service and total views.
`timescale 1ns/10ps
module flow_alarm_manager
#(
	parameter int unsigned CYCLES_PER_SEC = flow_alarm_pkg::CYCLES_PER_SEC // Shorten for simulation.
)
(
	// Clock and reset.
	input  wire logic                              MCLK,
	input  wire logic                              SYS_RST,
	// Avalon-MM register slave.
	input  wire logic [4:0]                        AVS_ADDRESS,
	input  wire logic                              AVS_READ,
	input  wire logic                              AVS_WRITE,
	input  wire logic [31:0]                       AVS_WRITEDATA,
	input  wire logic [3:0]                        AVS_BYTEENABLE,
	output logic      [31:0]                       AVS_READDATA,
	output logic                                   AVS_WAITREQUEST,
	// Flow measurement path.
	input  wire logic [flow_alarm_pkg::FLOW_W-1:0] FLOW_RATE,
	// External contact input, low means alarm.
	input  wire logic                              EXT_ALARM_N,
	// Operator keypad.
	input  wire logic                              KEY_ACT,
	input  wire logic                              KEY_NAV,
	input  wire logic [2:0]                        KEY_VIEW,
	input  wire logic                              KEY_ENTER,
	input  wire logic [5:0]                        KEY_PEND,
	// Alarm and display outputs.
	output logic      [2:0]                        ALARM_ACTIVE,
	output logic                                   ALARM_MSG_IND,
	output logic                                   BEEPER,
	output logic                                   RELAY_OUT,
	output logic      [2:0]                        VIEW_SEL
);

	// Configuration state.
	flow_alarm_pkg::cfg_s pend_ff;                  // Pending settings written by software.
	flow_alarm_pkg::cfg_s cfg_ff;                   // Settings in force.
	logic [15:0]          hihi_ff;                  // High-high flow limit.
	logic [15:0]          minfl_ff;                 // Minimum flow rate.
	logic                 commit;                   // Enter action from bus or keypad.
	logic                 bus_enter;                // Enter written over the bus.
	logic [2:0]           commit_sel;               // Select bits that an enter is about to store.

	// Bus handshake state.
	logic                 req;                      // A request is pending.
	logic                 done;                     // A request is answered at this edge.
	logic [31:0]          nxt_rdata;                // Read data selected by address.

	// External input synchroniser.
	logic                 ext_s1_ff;                // First stage, read only by the second.
	logic                 ext_s2_ff;                // Second stage.
	logic                 ext_s3_ff;                // Third stage.
	logic                 ext_low_ff;               // Filtered level, high while grounded.

	// Alarm state.
	logic                 armed_ff;                 // Low flow alarm armed after first flow.
	logic [2:0]           cause;                    // Raw alarm causes.
	logic [2:0]           qual;                     // Causes that may raise an alarm.
	logic [2:0]           raise;                    // Alarm raise strobes.
	logic [2:0]           rearm_ff;                 // Reselected source waits out the delay.
	logic [2:0]           latch_ff;                 // Latched alarms.
	logic [2:0]           active;                   // Latched alarms gated by the relay.
	logic                 any_act;                  // Any alarm active.
	logic                 any_act_d_ff;             // Previous any_act, for edge detection.

	// Timers and view.
	logic [flow_alarm_pkg::NUM_TMR-1:0] tmr_run;    // Timer runs while its condition holds.
	logic [flow_alarm_pkg::NUM_TMR-1:0] tmr_done;   // Timer has counted the full delay.
	flow_alarm_pkg::view_e view_ff;                 // Current view.

	// Bus decode. A request is answered once, then waitrequest rises again. Writes wait for the
	// edge at which the master sees waitrequest low, so a write never lands before the master knows.
	assign req        = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
	assign done       = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	assign bus_enter  = done & AVS_WRITE & (AVS_ADDRESS == flow_alarm_pkg::REG_ENTER)
		& AVS_BYTEENABLE[0] & AVS_WRITEDATA[flow_alarm_pkg::ENTER_BIT];
	assign commit     = bus_enter | KEY_ENTER;
	assign commit_sel = KEY_ENTER ? KEY_PEND[2:0] : pend_ff.sel; // Keypad enter wins, as in the commit.

	// Read multiplexer; unmapped addresses read as zero.
	always_comb
	begin
		nxt_rdata = 32'h0;
		case (AVS_ADDRESS)
			flow_alarm_pkg::REG_PEND:   nxt_rdata = {26'h0, pend_ff};
			flow_alarm_pkg::REG_CONFIG: nxt_rdata = {26'h0, cfg_ff};
			flow_alarm_pkg::REG_STATUS:
			begin
				nxt_rdata[2:0] = latch_ff;
				nxt_rdata[flow_alarm_pkg::ST_ANY_BIT] = any_act;
				nxt_rdata[flow_alarm_pkg::ST_VIEW_LSB +: 3] = view_ff;
				nxt_rdata[flow_alarm_pkg::ST_ARMED_BIT] = armed_ff;
				nxt_rdata[flow_alarm_pkg::ST_EXT_BIT] = ext_low_ff;
			end
			flow_alarm_pkg::REG_HIHI:   nxt_rdata = {16'h0, hihi_ff};
			flow_alarm_pkg::REG_MINFL:  nxt_rdata = {16'h0, minfl_ff};
			default:                    nxt_rdata = 32'h0;
		endcase
	end

	// Handshake: waitrequest drops for exactly one cycle, one edge after the request appears.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0;
		end
		else if (req)
		begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA    <= AVS_READ ? nxt_rdata : 32'h0;
		end
		else
			AVS_WAITREQUEST <= 1'b1; // Back to waiting so the same request is never answered twice.
	end

	// Register writes; a bus write lands at the edge that samples waitrequest low, when the master lets go.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			pend_ff  <= flow_alarm_pkg::CFG_RST;
			hihi_ff  <= flow_alarm_pkg::HIHI_RST;
			minfl_ff <= flow_alarm_pkg::MINFL_RST;
		end
		else if (done & AVS_WRITE)
		begin
			case (AVS_ADDRESS)
				flow_alarm_pkg::REG_PEND:
				begin
					if (AVS_BYTEENABLE[0])
						pend_ff <= AVS_WRITEDATA[5:0];
				end
				flow_alarm_pkg::REG_HIHI:
				begin
					if (AVS_BYTEENABLE[0])
						hihi_ff[7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						hihi_ff[15:8] <= AVS_WRITEDATA[15:8];
				end
				flow_alarm_pkg::REG_MINFL:
				begin
					if (AVS_BYTEENABLE[0])
						minfl_ff[7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						minfl_ff[15:8] <= AVS_WRITEDATA[15:8];
				end
				default:
				begin
					// Unmapped or read-only offsets ignore writes.
				end
			endcase
		end
		else if (KEY_ENTER)
			pend_ff <= KEY_PEND; // The keypad enter commits its own pending selection, so mirror it here.
	end

	// Commit of pending settings. Until an enter, stored settings never move.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			cfg_ff <= flow_alarm_pkg::CFG_RST;
		else if (KEY_ENTER)
			cfg_ff <= KEY_PEND;
		else if (bus_enter)
			cfg_ff <= pend_ff;
	end

	// Three-stage synchroniser; the level moves only when stages two and three agree.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			ext_s1_ff  <= 1'b1;
			ext_s2_ff  <= 1'b1;
			ext_s3_ff  <= 1'b1;
			ext_low_ff <= 1'b0;
		end
		else
		begin
			ext_s1_ff <= EXT_ALARM_N;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
			if (ext_s2_ff == ext_s3_ff)
				ext_low_ff <= ~ext_s3_ff;
		end
	end

	// Low flow stays disarmed after boot until flow first rises above the minimum.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			armed_ff <= 1'b0;
		else if (FLOW_RATE > minfl_ff)
			armed_ff <= 1'b1;
	end

	// Raw causes. Zero flow counts as low flow even with the minimum parked at zero.
	assign cause[flow_alarm_pkg::SRC_OVER] = FLOW_RATE > hihi_ff;
	assign cause[flow_alarm_pkg::SRC_EXT]  = ext_low_ff;
	assign cause[flow_alarm_pkg::SRC_LOW]  = armed_ff & ((FLOW_RATE < minfl_ff) | (FLOW_RATE == 16'h0));

	// A cause only counts when its source is selected and the relay is enabled.
	assign qual    = cause & cfg_ff.sel & {3{cfg_ff.relay_en}};
	assign tmr_run = {~KEY_ACT & ~KEY_NAV, qual};

	// Per-source raise and latch. The latch ignores the cause going away; only deselection clears it.
	genvar gi;
	generate
		for (gi = 0; gi < flow_alarm_pkg::NUM_SRC; gi++)
		begin : g_src
			// External alarms always wait; the others wait only after a reselection.
			assign raise[gi] = qual[gi] & ((gi == flow_alarm_pkg::SRC_EXT) | rearm_ff[gi] ? tmr_done[gi] : 1'b1);

			// An enter judges the incoming selection; the stored one still shows the old bit at that edge.
			always_ff @(posedge MCLK)
			begin
				if (SYS_RST)
					rearm_ff[gi] <= 1'b0;
				else if (commit)
					rearm_ff[gi] <= commit_sel[gi] & cause[gi] & ~latch_ff[gi] & ~raise[gi];
				else if (!cfg_ff.sel[gi] || raise[gi])
					rearm_ff[gi] <= 1'b0;
			end

			always_ff @(posedge MCLK)
			begin
				if (SYS_RST)
					latch_ff[gi] <= 1'b0;
				else if (raise[gi])
					latch_ff[gi] <= 1'b1;
				else if (!cfg_ff.sel[gi])
					latch_ff[gi] <= 1'b0;
			end
		end
	endgenerate

	// Second-tick timers. Each restarts from zero whenever its condition drops, then saturates.
	generate
		for (gi = 0; gi < flow_alarm_pkg::NUM_TMR; gi++)
		begin : g_tmr
			logic [31:0] pre_ff;                    // Cycles within the current second.
			logic [3:0]  sec_ff;                    // Whole seconds counted.

			assign tmr_done[gi] = sec_ff == flow_alarm_pkg::DELAY_TICKS;

			always_ff @(posedge MCLK)
			begin
				if (SYS_RST || !tmr_run[gi])
				begin
					pre_ff <= 32'h0;
					sec_ff <= 4'h0;
				end
				else if (!tmr_done[gi])
				begin
					if (pre_ff == 32'(CYCLES_PER_SEC - 1))
					begin
						pre_ff <= 32'h0;
						sec_ff <= sec_ff + 4'h1;
					end
					else
						pre_ff <= pre_ff + 32'h1;
				end
			end
		end
	endgenerate

	// The relay gates what the outside sees, so re-enabling shows a still-latched alarm again.
	assign active  = latch_ff & {3{cfg_ff.relay_en}};
	assign any_act = |active;

	// Notification and view outputs, all registered; the view shows one edge after it is chosen.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			ALARM_ACTIVE  <= 3'h0;
			ALARM_MSG_IND <= 1'b0;
			BEEPER        <= 1'b0;
			RELAY_OUT     <= 1'b0;
			VIEW_SEL      <= 3'h0;
			any_act_d_ff  <= 1'b0;
		end
		else
		begin
			ALARM_ACTIVE  <= active;
			ALARM_MSG_IND <= any_act & cfg_ff.msg_en;
			BEEPER        <= any_act & cfg_ff.beep_en;
			RELAY_OUT     <= any_act;
			VIEW_SEL      <= view_ff;
			any_act_d_ff  <= any_act;
		end
	end

	// View selection: navigation wins, then the service view hold, then alarm onset, then the idle timeout.
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			view_ff <= flow_alarm_pkg::VIEW_FLOW;
		else if (KEY_NAV)
			view_ff <= flow_alarm_pkg::view_e'(KEY_VIEW);
		else if (view_ff == flow_alarm_pkg::VIEW_SERVICE)
			view_ff <= view_ff;
		else if (any_act && !any_act_d_ff)
			view_ff <= flow_alarm_pkg::VIEW_ALARM;
		else if (tmr_done[flow_alarm_pkg::TMR_IDLE])
		begin
			case (view_ff)
				flow_alarm_pkg::VIEW_TOTAL, flow_alarm_pkg::VIEW_TOTAL_RST:
					view_ff <= any_act ? flow_alarm_pkg::VIEW_ALARM : view_ff;
				flow_alarm_pkg::VIEW_ALARM:
					view_ff <= view_ff;
				default:
					view_ff <= any_act ? flow_alarm_pkg::VIEW_ALARM : flow_alarm_pkg::VIEW_FLOW;
			endcase
		end
	end

	// Checks.
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	sequence s_pin_low;
		!EXT_ALARM_N [*4];
	endsequence

	property p_commit_only;
		(cfg_ff != $past(cfg_ff)) |-> ($past(KEY_ENTER) || $past(bus_enter));
	endproperty
	a_commit_only: assert property (p_commit_only) else $error("Stored settings moved without enter.");
	property p_relay_gate;
		!cfg_ff.relay_en |=> (ALARM_ACTIVE == 3'h0) && !RELAY_OUT;
	endproperty
	a_relay_gate: assert property (p_relay_gate) else $error("Alarm active with relay disabled.");
	property p_clear_by_deselect;
		((~latch_ff & $past(latch_ff)) & $past(cfg_ff.sel)) == 3'h0;
	endproperty
	a_clear_by_deselect: assert property (p_clear_by_deselect) else $error("Latch cleared while selected.");
	property p_msg;
		(any_act && cfg_ff.msg_en) |=> ALARM_MSG_IND;
	endproperty
	a_msg: assert property (p_msg) else $error("Message indication missing.");
	property p_armed;
		!armed_ff |-> !latch_ff[flow_alarm_pkg::SRC_LOW];
	endproperty
	a_armed: assert property (p_armed) else $error("Low flow alarm before arming.");
	property p_ext_delay;
		$rose(latch_ff[flow_alarm_pkg::SRC_EXT]) |-> $past(tmr_done[flow_alarm_pkg::SRC_EXT]) && $past(ext_low_ff);
	endproperty
	a_ext_delay: assert property (p_ext_delay) else $error("External alarm raised early.");
	property p_service;
		(view_ff == flow_alarm_pkg::VIEW_SERVICE) && !KEY_NAV |=> view_ff == flow_alarm_pkg::VIEW_SERVICE;
	endproperty
	a_service: assert property (p_service) else $error("Service view left without navigation.");
	property p_over_cause;
		$rose(latch_ff[flow_alarm_pkg::SRC_OVER]) |-> $past(FLOW_RATE) > $past(hihi_ff);
	endproperty
	a_over_cause: assert property (p_over_cause) else $error("Over pressure alarm without cause.");
	property p_idle_alarm;
		tmr_done[flow_alarm_pkg::TMR_IDLE] && any_act && !KEY_NAV
			&& (view_ff != flow_alarm_pkg::VIEW_SERVICE) |=> view_ff == flow_alarm_pkg::VIEW_ALARM;
	endproperty
	a_idle_alarm: assert property (p_idle_alarm) else $error("Alarm view not made default.");
	property p_sync;
		s_pin_low |=> ext_low_ff;
	endproperty
	a_sync: assert property (p_sync) else $error("Grounded input not seen after sync.");

endmodule

// File: testbench/flow_field_model.sv
// Far side of the alarm block: the flow sensor path and the external contact.
// Assumes the bench sets the commanded flow and contact state on the rising edge.
`timescale 1ns/10ps
module flow_field_model
(
	// Clock.
	input  wire logic        mclk,
	// Commands from the bench.
	input  wire logic [15:0] flow_cmd,
	input  wire logic        contact_closed,
	// Lines into the block.
	output logic      [15:0] flow_rate   = 16'h0000,
	output logic             ext_alarm_n = 1'b1
);
	// The sensor path hands over one registered sample per clock, as real logic would.
	always_ff @(posedge mclk)
	begin
		flow_rate <= flow_cmd;
	end
	// A closed contact grounds the pin; an open one lets the pull-up take it high.
	always_ff @(posedge mclk)
	begin
		ext_alarm_n <= !contact_closed;
	end
endmodule

// File: testbench/flow_alarm_manager_bench.sv
// Self-checking bench for the flow alarm supervisor, driven through its register bus and keypad.
// Assumes the one-second tick is shortened to 10 cycles, so every 10 s delay is 100 cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module flow_alarm_manager_bench;
	localparam logic [31:0] ALL = 32'hffffffff; // Compare every bit.
	logic        mclk            = 1'b0;  // System clock.
	logic        sys_rst         = 1'b1;  // Held for 20 cycles at start.
	logic [4:0]  avs_address     = 5'h00;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [15:0] flow_cmd        = 16'h0; // Commanded flow.
	logic        contact_closed  = 1'b0;  // External contact state.
	logic [15:0] flow_rate;
	logic        ext_alarm_n;
	logic        key_act         = 1'b0;
	logic        key_nav         = 1'b0;
	logic [2:0]  key_view        = 3'h0;
	logic        key_enter       = 1'b0;
	logic [5:0]  key_pend        = 6'h00;
	logic [2:0]  alarm_active;
	logic        alarm_msg_ind;
	logic        beeper;
	logic        relay_out;
	logic [2:0]  view_sel;
	logic [31:0] rd;                      // Last read word.
	int          failures        = 0;
	int          samples_checked = 0;

	flow_alarm_manager #(.CYCLES_PER_SEC(10)) flow_alarm_manager_i (.MCLK(mclk), .SYS_RST(sys_rst),
		.AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.FLOW_RATE(flow_rate), .EXT_ALARM_N(ext_alarm_n), .KEY_ACT(key_act), .KEY_NAV(key_nav),
		.KEY_VIEW(key_view), .KEY_ENTER(key_enter), .KEY_PEND(key_pend), .ALARM_ACTIVE(alarm_active),
		.ALARM_MSG_IND(alarm_msg_ind), .BEEPER(beeper), .RELAY_OUT(relay_out), .VIEW_SEL(view_sel));
	flow_field_model flow_field_model_i (.mclk(mclk), .flow_cmd(flow_cmd), .contact_closed(contact_closed),
		.flow_rate(flow_rate), .ext_alarm_n(ext_alarm_n));

	// Free-running 250 MHz clock.
	always #2 mclk = ~mclk;

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One bus cycle; the request stands until waitrequest is sampled low, with a bounded wait.
	task automatic avs_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// A slave that never answers ends the run.
		if (avs_waitrequest !== 1'b0)
		begin
			failures++;
			print_verdict();
		end
	endtask

	// Reads a register and compares the masked word.
	task automatic reg_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		avs_xfer(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask

	// Loads the pending word and commits it with the bus enter action.
	task automatic commit(input logic [5:0] c);
		avs_xfer(1'b1, flow_alarm_pkg::REG_PEND, {26'h0, c});
		avs_xfer(1'b1, flow_alarm_pkg::REG_ENTER, 32'h1);
	endtask

	// Commits from the keypad instead of the bus.
	task automatic key_commit(input logic [5:0] c);
		@(posedge mclk);
		key_pend <= c;
		key_enter <= 1'b1;
		@(posedge mclk);
		key_enter <= 1'b0;
	endtask

	// One keypad pulse: navigation to a view, or plain activity.
	task automatic key_pulse(input logic isnav, input logic [2:0] v);
		@(posedge mclk);
		key_nav <= isnav;
		key_act <= !isnav;
		key_view <= v;
		@(posedge mclk);
		key_nav <= 1'b0;
		key_act <= 1'b0;
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Waits a bounded time for the alarm word; a miss ends the run.
	task automatic wait_alarm(input logic [2:0] e, input int lim);
		for (int i = 0; i < lim && alarm_active !== e; i++)
			@(posedge mclk);
		`CHK(alarm_active, e)
		if (alarm_active !== e)
			print_verdict();
	endtask

	// Main sequence; config bits are relay, beeper, message, then low, ext, over selects.
	initial
	begin
		hold(20);
		sys_rst <= 1'b0;
		hold(1);
		`CHK({alarm_active, view_sel, avs_waitrequest}, 7'h01)
		reg_chk(flow_alarm_pkg::REG_HIHI, ALL, 32'h0000ffff);
		reg_chk(5'h1c, ALL, 32'h0); // Unmapped place reads zero.
		// Low flow stays disarmed before the first flow.
		commit(6'h24);
		hold(120);
		`CHK(alarm_active, 3'b000)
		avs_xfer(1'b1, flow_alarm_pkg::REG_MINFL, 32'h14);
		flow_cmd <= 16'd50;
		hold(5);
		reg_chk(flow_alarm_pkg::REG_STATUS, 32'h80, 32'h80);
		flow_cmd <= 16'd5;
		wait_alarm(3'b100, 150);
		flow_cmd <= 16'd50;
		hold(20);
		`CHK(alarm_active, 3'b100)
		commit(6'h20);
		wait_alarm(3'b000, 10);
		// Pending word waits for enter; read-only config ignores writes.
		avs_xfer(1'b1, flow_alarm_pkg::REG_PEND, 32'h39);
		avs_xfer(1'b1, flow_alarm_pkg::REG_CONFIG, 32'h3f);
		reg_chk(flow_alarm_pkg::REG_CONFIG, ALL, 32'h20);
		avs_xfer(1'b1, flow_alarm_pkg::REG_ENTER, 32'h1);
		reg_chk(flow_alarm_pkg::REG_CONFIG, ALL, 32'h39);
		reg_chk(flow_alarm_pkg::REG_ENTER, ALL, 32'h0);
		// Over-limit flow raises at once and latches.
		avs_xfer(1'b1, flow_alarm_pkg::REG_HIHI, 32'h64);
		flow_cmd <= 16'd200;
		wait_alarm(3'b001, 10);
		hold(2);
		`CHK({alarm_msg_ind, beeper, relay_out}, 3'b111)
		`CHK(view_sel, flow_alarm_pkg::VIEW_ALARM)
		flow_cmd <= 16'd50;
		hold(20);
		`CHK(alarm_active, 3'b001)
		// Relay off hides the alarm and its default view; relay on shows it again.
		commit(6'h19);
		wait_alarm(3'b000, 10);
		key_pulse(1'b1, flow_alarm_pkg::VIEW_OTHER);
		hold(120);
		`CHK(view_sel, flow_alarm_pkg::VIEW_FLOW)
		key_commit(6'h39);
		wait_alarm(3'b001, 10);
		key_pulse(1'b1, flow_alarm_pkg::VIEW_OTHER);
		hold(120);
		`CHK(view_sel, flow_alarm_pkg::VIEW_ALARM)
		key_pulse(1'b1, flow_alarm_pkg::VIEW_SERVICE);
		hold(120);
		`CHK(view_sel, flow_alarm_pkg::VIEW_SERVICE)
		key_commit(6'h38);
		wait_alarm(3'b000, 10);
		// Reselection with the cause present waits the full delay; message only.
		flow_cmd <= 16'd200;
		key_commit(6'h29);
		hold(50);
		`CHK(alarm_active, 3'b000)
		wait_alarm(3'b001, 80);
		hold(2);
		`CHK({alarm_msg_ind, beeper}, 2'b10)
		key_commit(6'h28);
		flow_cmd <= 16'd50;
		// Grounded contact alarms after the delay and needs release plus deselect.
		commit(6'h22);
		contact_closed <= 1'b1;
		hold(50);
		`CHK(alarm_active, 3'b000)
		wait_alarm(3'b010, 80);
		contact_closed <= 1'b0;
		hold(20);
		`CHK(alarm_active, 3'b010)
		commit(6'h20);
		wait_alarm(3'b000, 10);
		// Idle return to the flow view restarts on keypad activity.
		key_pulse(1'b1, flow_alarm_pkg::VIEW_OTHER);
		hold(60);
		key_pulse(1'b0, 3'h0);
		hold(60);
		`CHK(view_sel, flow_alarm_pkg::VIEW_OTHER)
		hold(60);
		`CHK(view_sel, flow_alarm_pkg::VIEW_FLOW)
		print_verdict();
	end
endmodule
